// >>> acpush_defs.svh
/*
  Constants of the actuator status and push-completion block: widths,
  field codes, push and creep values and timing figures.
  Assumes inclusion by bare name before the package and the modules.
*/
// What this block does
// R1: Homing-finished rises after first homing completes
// R2: Homing-finished holds until alarm or power loss
// R3: Emergency stop alone keeps homing-finished set
// R4: Absolute variant with taught home: set at power-up
// R5: Alarm output low during alarm, else high
// R6: Estop output low while active; home on release
// R7: In-motion output high while the motor moves
// R8: Sixteen table entries of six fields each; the code stores seven (pos, speed, acc, push, width, max_acc, mode)
// R9: Target absolute or incremental per entry mode
// R10: Other fields rejected until position written
// R11: Position stored rounded to lead resolution
// R12: Push zero means positioning, nonzero means push
// R13: Positioning: done and number once within width
// R14: Push: done after current held determination time
// R15: Push approach at fixed 75 RPM creep
// R16: Push field is a current limit percentage
// R17: Host keeps push limit at 30 percent or more
// R18: Keep pushing with the limit after success
// R19: Push miss: number only, done stays low
// R20: Alarm and estop outputs are active low
// R21: Host selects entry with four weighted bits
// R22: Push timer restarts when current drops below
`ifndef ACPUSH_DEFS_SVH
`define ACPUSH_DEFS_SVH

// ============================================================
// Widths and table entry count
`define ACP_POS_W      16
`define ACP_IDX_W      4
`define ACP_ENTRIES    16
`define ACP_ACC_W      8
`define ACP_PCT_W      8
`define ACP_FLD_W      3
`define ACP_PCNT_W     22

// ============================================================
// Table field codes
`define ACP_FLD_POS    3'h0
`define ACP_FLD_SPEED  3'h1
`define ACP_FLD_ACC    3'h2
`define ACP_FLD_PUSH   3'h3
`define ACP_FLD_WIDTH  3'h4
`define ACP_FLD_MAXACC 3'h5
`define ACP_FLD_MODE   3'h6

// ============================================================
// Values and timing
`define ACP_PUSH_OFF   8'h00
`define ACP_PUSH_MIN   8'h1e
`define ACP_CREEP_RPM  8'h4b
`define ACP_PUSH_MS    255
`define ACP_CLK_HZ     10000000
`define ACP_MS_PER_S   1000

`endif

// >>> acpush_pkg.sv
/*
  Types of the actuator status and push-completion block.
  Assumes acpush_defs.svh is on the include path.
*/
`include "acpush_defs.svh"
`default_nettype none

package acpush_pkg;
  typedef logic [`ACP_POS_W-1:0] acpush_pos_t;
  typedef logic [`ACP_IDX_W-1:0] acpush_idx_t;
  typedef logic [`ACP_PCT_W-1:0] acpush_pct_t;
  typedef logic [`ACP_ACC_W-1:0] acpush_acc_t;
  typedef logic [`ACP_FLD_W-1:0] acpush_fld_t;

  // One table entry
  typedef struct packed {
    acpush_pos_t pos;
    acpush_pos_t speed;
    acpush_acc_t acc;
    acpush_pct_t push;
    acpush_pos_t width;
    logic        max_acc;
    logic        incr;
    logic        pos_ok;
  } acpush_ent_t;

  typedef enum logic [2:0] {
    st_idle, st_home, st_load, st_move, st_push, st_held, st_miss
  } acpush_st_t;
endpackage

`default_nettype wire

// >>> acpush_rnd_if.sv
/*
  Interface between the sequencer and the position rounder.
  Assumes both ends run combinationally in one clock domain.
*/
`default_nettype none

interface acpush_rnd_if;
  import acpush_pkg::*;
  acpush_pos_t raw;
  acpush_pos_t res;
  acpush_pos_t rounded;

  modport client (output raw, output res, input rounded);
  modport rounder (input raw, input res, output rounded);
endinterface

`default_nettype wire

// >>> acpush_round.sv
/*
  Rounds a written position to the nearest multiple of the lead
  resolution. Assumes resolution zero means no rounding.
*/
`include "acpush_defs.svh"
`default_nettype none

module acpush_round (
  // Rounding request and result
  acpush_rnd_if.rounder rnd
);
  import acpush_pkg::*;

  logic [`ACP_POS_W:0]     sum;
  logic [`ACP_POS_W:0]     quo;
  logic [2*`ACP_POS_W+1:0] prod;

  // ============================================================
  // Nearest multiple, clipped downward on overflow
  always_comb begin
    sum  = {1'b0, rnd.raw} + {2'b00, rnd.res[`ACP_POS_W-1:1]};
    quo  = '0;
    prod = '0;
    if (rnd.res == '0) begin
      rnd.rounded = rnd.raw;
    end else begin
      quo  = sum / {1'b0, rnd.res};
      prod = quo * {1'b0, rnd.res};
      if (prod[2*`ACP_POS_W+1:`ACP_POS_W] != '0) begin
        rnd.rounded = rnd.raw - (rnd.raw % rnd.res);
      end else begin
        rnd.rounded = prod[`ACP_POS_W-1:0];
      end
    end
  end
endmodule

`default_nettype wire

// >>> acpush_top.sv
/*
  Status outputs, position table and move completion of a single-axis
  actuator controller. Assumes a motion core on core_clk executes the
  commands and reports position, current, motion, alarm and homing;
  parallel I/O pins arrive asynchronously.
*/
`include "acpush_defs.svh"
`default_nettype none

module acpush_top #(
  parameter int unsigned PUSH_CYC =
    `ACP_PUSH_MS * (`ACP_CLK_HZ / `ACP_MS_PER_S)
) (
  // Clock, reset, enable
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  // Parallel I/O input pins
  input  wire logic                pin_start,
  input  wire acpush_pkg::acpush_idx_t pin_sel,
  input  wire logic                pin_hold_n,
  input  wire logic                pin_estop_n,
  // Configuration
  input  wire logic                abs_variant,
  input  wire logic                home_taught,
  input  wire acpush_pkg::acpush_pos_t lead_res,
  // Table entry port
  input  wire logic                tbl_wr,
  input  wire acpush_pkg::acpush_idx_t tbl_idx,
  input  wire acpush_pkg::acpush_fld_t tbl_fld,
  input  wire acpush_pkg::acpush_pos_t tbl_data,
  output logic                     tbl_reject,
  output logic                     tbl_push_low,
  // Motion core status
  input  wire logic                mc_home_ok,
  input  wire logic                mc_alarm,
  input  wire logic                mc_moving,
  input  wire acpush_pkg::acpush_pos_t mc_pos,
  input  wire acpush_pkg::acpush_pct_t mc_cur_pct,
  // Motion core commands
  output logic                     cmd_go,
  output logic                     cmd_home,
  output logic                     cmd_hold,
  output acpush_pkg::acpush_pos_t  cmd_target,
  output acpush_pkg::acpush_pos_t  cmd_speed,
  output acpush_pkg::acpush_acc_t  cmd_acc,
  output logic                     cmd_max_acc,
  output acpush_pkg::acpush_pct_t  cmd_push_pct,
  output logic                     cmd_push_mode,
  output logic                     cmd_creep,
  output acpush_pkg::acpush_pct_t  cmd_creep_rpm,
  // Status output pins
  output logic                     out_home_done,
  output logic                     out_alarm_n,
  output logic                     out_estop_n,
  output logic                     out_moving,
  output logic                     out_pos_done,
  output acpush_pkg::acpush_idx_t  out_done_pos
);
  import acpush_pkg::*;

  localparam logic [`ACP_PCNT_W-1:0] PC_LAST =
    `ACP_PCNT_W'(PUSH_CYC - 1);

  // ============================================================
  // State
  typedef struct packed {
    logic                     s1_start;
    logic                     s2_start;
    logic                     s3_start;
    acpush_idx_t              s1_sel;
    acpush_idx_t              s2_sel;
    logic                     s1_hold;
    logic                     s2_hold;
    logic                     s1_estop;
    logic                     s2_estop;
    logic                     s3_estop;
    logic                     init_done;
    acpush_st_t               st;
    acpush_idx_t              idx;
    acpush_pos_t              target;
    logic                     home_done;
    logic                     home;
    logic                     alarm_n;
    logic                     estop_n;
    logic                     moving;
    logic                     pos_done;
    acpush_idx_t              done_pos;
    logic [`ACP_PCNT_W-1:0]   pcnt;
    logic                     go;
    logic                     creep;
    logic                     reject;
    logic                     push_low;
    acpush_ent_t [`ACP_ENTRIES-1:0] tbl;
  } acpush_state_t;

  localparam acpush_state_t RST_STATE = '{
    s1_hold: 1'b1, s2_hold: 1'b1,
    s1_estop: 1'b1, s2_estop: 1'b1, s3_estop: 1'b1,
    st: st_idle, alarm_n: 1'b1, estop_n: 1'b1,
    default: '0
  };

  acpush_state_t s_r;
  acpush_state_t s_nxt;

  acpush_rnd_if rnd ();

  acpush_ent_t  sel;
  acpush_pos_t  diff;
  logic         in_band;
  logic         start_rise;
  logic         estop_rise;
  logic         run_ok;

  acpush_round u_round (
    .rnd (rnd.rounder)
  );

  // ============================================================
  // Derived terms
  assign sel        = s_r.tbl[s_r.idx];
  assign diff       = (s_r.target >= mc_pos) ? s_r.target - mc_pos
                                             : mc_pos - s_r.target;
  assign in_band    = diff <= sel.width;
  assign start_rise = s_r.s2_start & ~s_r.s3_start;
  assign estop_rise = s_r.s2_estop & ~s_r.s3_estop;
  assign run_ok     = s_r.s2_estop & ~mc_alarm;
  assign rnd.raw    = tbl_data;
  assign rnd.res    = lead_res;

  // ============================================================
  // Next state
  always_comb begin
    s_nxt          = s_r;
    s_nxt.s1_start = pin_start;
    s_nxt.s2_start = s_r.s1_start;
    s_nxt.s3_start = s_r.s2_start;
    s_nxt.s1_sel   = pin_sel;
    s_nxt.s2_sel   = s_r.s1_sel;
    s_nxt.s1_hold  = pin_hold_n;
    s_nxt.s2_hold  = s_r.s1_hold;
    s_nxt.s1_estop = pin_estop_n;
    s_nxt.s2_estop = s_r.s1_estop;
    s_nxt.s3_estop = s_r.s2_estop;
    s_nxt.go       = 1'b0;
    s_nxt.reject   = 1'b0;
    s_nxt.push_low = 1'b0;
    s_nxt.alarm_n  = ~mc_alarm; // R5 R20
    s_nxt.estop_n  = s_r.s2_estop; // R6 R20
    s_nxt.moving   = mc_moving; // R7

    // Power-up preparation
    if (!s_r.init_done) begin
      s_nxt.init_done = 1'b1;
      s_nxt.pos_done  = 1'b1;
      if (abs_variant && home_taught) begin
        s_nxt.home_done = 1'b1; // R4
      end
    end

    // Homing flag: alarm clears, estop does not, set wins
    if (mc_alarm) begin
      s_nxt.home_done = 1'b0; // R2 R3
    end
    if (mc_home_ok) begin
      s_nxt.home_done = 1'b1; // R1
      s_nxt.home      = 1'b0;
    end
    if (estop_rise) begin
      s_nxt.home = 1'b1; // R6
    end

    // Table entry writes
    if (tbl_wr) begin
      if (tbl_fld != `ACP_FLD_POS && !s_r.tbl[tbl_idx].pos_ok) begin
        s_nxt.reject = 1'b1; // R10
      end else begin
        case (tbl_fld)
          `ACP_FLD_POS: begin
            s_nxt.tbl[tbl_idx].pos    = rnd.rounded; // R11
            s_nxt.tbl[tbl_idx].pos_ok = 1'b1;
          end
          `ACP_FLD_SPEED: begin
            s_nxt.tbl[tbl_idx].speed = tbl_data; // R8
          end
          `ACP_FLD_ACC: begin
            s_nxt.tbl[tbl_idx].acc = tbl_data[`ACP_ACC_W-1:0];
          end
          `ACP_FLD_PUSH: begin
            s_nxt.tbl[tbl_idx].push = tbl_data[`ACP_PCT_W-1:0]; // R16
            if (tbl_data[`ACP_PCT_W-1:0] != `ACP_PUSH_OFF &&
                tbl_data[`ACP_PCT_W-1:0] < `ACP_PUSH_MIN) begin
              s_nxt.push_low = 1'b1; // R17
            end
          end
          `ACP_FLD_WIDTH: begin
            s_nxt.tbl[tbl_idx].width = tbl_data;
          end
          `ACP_FLD_MAXACC: begin
            s_nxt.tbl[tbl_idx].max_acc = tbl_data[0];
          end
          `ACP_FLD_MODE: begin
            s_nxt.tbl[tbl_idx].incr = tbl_data[0]; // R9
          end
          default: begin
            s_nxt.reject = 1'b1;
          end
        endcase
      end
    end

    // Move sequencer
    case (s_r.st)
      st_idle, st_held, st_miss: begin
        if (start_rise && run_ok) begin
          s_nxt.idx      = s_r.s2_sel; // R21
          s_nxt.pos_done = 1'b0;
          s_nxt.done_pos = '0;
          s_nxt.pcnt     = '0;
          s_nxt.creep    = 1'b0;
          if (!s_r.home_done) begin
            s_nxt.home = 1'b1; // R1
            s_nxt.st   = st_home;
          end else begin
            s_nxt.st = st_load;
          end
        end
      end
      st_home: begin
        if (s_r.home_done) begin
          s_nxt.st = st_load;
        end
      end
      st_load: begin
        s_nxt.target = sel.incr ? mc_pos + sel.pos : sel.pos; // R9
        s_nxt.go     = 1'b1;
        s_nxt.st     = st_move;
      end
      st_move: begin
        if (in_band) begin
          if (sel.push == `ACP_PUSH_OFF) begin
            s_nxt.pos_done = 1'b1; // R12 R13
            s_nxt.done_pos = s_r.idx;
            s_nxt.st       = st_idle;
          end else begin
            s_nxt.creep = 1'b1; // R12 R15
            s_nxt.pcnt  = '0;
            s_nxt.st    = st_push;
          end
        end
      end
      st_push: begin
        if (mc_cur_pct >= sel.push) begin
          if (s_r.pcnt == PC_LAST) begin
            s_nxt.pos_done = 1'b1; // R14
            s_nxt.done_pos = s_r.idx;
            s_nxt.st       = st_held; // R18
          end else begin
            s_nxt.pcnt = s_r.pcnt + 1'b1;
          end
        end else begin
          s_nxt.pcnt = '0; // R22
          if (!mc_moving) begin
            s_nxt.done_pos = s_r.idx; // R19
            s_nxt.creep    = 1'b0;
            s_nxt.st       = st_miss;
          end
        end
      end
      default: begin
        s_nxt.st = st_idle;
      end
    endcase

    // Emergency stop or alarm abandons the move
    if (!run_ok) begin
      s_nxt.st       = st_idle;
      s_nxt.creep    = 1'b0;
      s_nxt.go       = 1'b0;
      s_nxt.pcnt     = '0;
    end
    if (!s_r.s2_estop) begin
      s_nxt.done_pos = '0;
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_r <= RST_STATE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign tbl_reject    = s_r.reject;
  assign tbl_push_low  = s_r.push_low;
  assign cmd_go        = s_r.go;
  assign cmd_home      = s_r.home;
  assign cmd_hold      = ~s_r.s2_hold;
  assign cmd_target    = s_r.target;
  assign cmd_speed     = sel.speed;
  assign cmd_acc       = sel.acc;
  assign cmd_max_acc   = sel.max_acc;
  assign cmd_push_pct  = sel.push; // R16 R18
  assign cmd_push_mode = sel.push != `ACP_PUSH_OFF; // R12
  assign cmd_creep     = s_r.creep;
  assign cmd_creep_rpm = `ACP_CREEP_RPM; // R15
  assign out_home_done = s_r.home_done;
  assign out_alarm_n   = s_r.alarm_n;
  assign out_estop_n   = s_r.estop_n;
  assign out_moving    = s_r.moving;
  assign out_pos_done  = s_r.pos_done;
  assign out_done_pos  = s_r.done_pos;

  // ============================================================
  // Checks
  a_home_set_ok: // R1
    assert property (@(posedge core_clk) disable iff (!rst_b)
      mc_home_ok && clk_en |=> out_home_done)
    else $error("homing finished not set after home report");

  a_home_alarm_clr: // R2
    assert property (@(posedge core_clk) disable iff (!rst_b)
      mc_alarm && !mc_home_ok && clk_en && s_r.init_done
      |=> !out_home_done)
    else $error("homing finished survived an alarm");

  a_home_estop_keep: // R3
    assert property (@(posedge core_clk) disable iff (!rst_b)
      out_home_done && !mc_alarm && clk_en |=> out_home_done)
    else $error("homing finished dropped without alarm");

  a_abs_home_up: // R4
    assert property (@(posedge core_clk) disable iff (!rst_b)
      !s_r.init_done && abs_variant && home_taught && clk_en
      |=> out_home_done)
    else $error("taught absolute home not reported at power-up");

  a_alarm_pin_low: // R5
    assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en |=> out_alarm_n == !$past(mc_alarm))
    else $error("alarm output does not follow alarm condition");

  a_estop_pin_low: // R6
    assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en |=> out_estop_n == $past(s_r.s2_estop))
    else $error("estop output does not follow estop input");

  a_moving_follow: // R7
    assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en |=> out_moving == $past(mc_moving))
    else $error("in-motion output does not follow the motor");

  a_write_reject: // R10
    assert property (@(posedge core_clk) disable iff (!rst_b)
      tbl_wr && clk_en && tbl_fld != `ACP_FLD_POS &&
      !s_r.tbl[tbl_idx].pos_ok |=> tbl_reject)
    else $error("field write before position not rejected");

  a_round_mult: // R11
    assert property (@(posedge core_clk) disable iff (!rst_b)
      rnd.res != '0 |-> (rnd.rounded % rnd.res) == '0)
    else $error("rounded position not a resolution multiple");

  a_plain_finish: // R13
    assert property (@(posedge core_clk) disable iff (!rst_b)
      s_r.st == st_move && in_band && sel.push == `ACP_PUSH_OFF &&
      run_ok && clk_en
      |=> out_pos_done && out_done_pos == $past(s_r.idx))
    else $error("positioning finish missing inside the band");

  a_push_finish: // R14
    assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(out_pos_done) && $past(s_r.st) == st_push
      |-> $past(s_r.pcnt) == PC_LAST)
    else $error("push finish before determination time");

  a_push_restart: // R22
    assert property (@(posedge core_clk) disable iff (!rst_b)
      s_r.st == st_push && mc_cur_pct < sel.push && clk_en
      |=> s_r.pcnt == '0)
    else $error("push timer not restarted on low current");

  a_push_creep: // R15
    assert property (@(posedge core_clk) disable iff (!rst_b)
      s_r.st == st_push |-> cmd_creep &&
      cmd_creep_rpm == `ACP_CREEP_RPM)
    else $error("push approach not at creep speed");

  a_push_held: // R18
    assert property (@(posedge core_clk) disable iff (!rst_b)
      s_r.st == st_held |-> cmd_creep && cmd_push_mode)
    else $error("pushing stopped after push success");

  a_push_miss: // R19
    assert property (@(posedge core_clk) disable iff (!rst_b)
      s_r.st == st_miss |-> !out_pos_done &&
      out_done_pos == s_r.idx)
    else $error("push miss shows positioning finished");
endmodule

`default_nettype wire

// >>> acpush_mc_model.sv
/*
  Behavioural motion core facing the actuator push block.
  Assumes one core_clk domain and synchronous active-low reset.
*/
`default_nettype none

module acpush_mc_model (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // Commands from the block
  input  wire logic                     cmd_go,
  input  wire logic                     cmd_home,
  input  wire logic                     cmd_creep,
  input  wire acpush_pkg::acpush_pos_t  cmd_target,
  // Status back to the block
  output logic                          mc_home_ok,
  output logic                          mc_moving,
  output acpush_pkg::acpush_pos_t       mc_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  import acpush_pkg::*;
  acpush_pos_t tgt_r;
  logic [2:0]  hc_r;
  logic [1:0]  sc_r;

  // ============================================================
  // Homing answer and travel
  assign mc_home_ok = (hc_r == 3'h5);
  assign mc_moving  = (mc_pos != tgt_r);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mc_pos <= 16'h0000;
      tgt_r  <= 16'h0000;
      hc_r   <= 3'h0;
      sc_r   <= 2'h0;
    end else begin
      hc_r <= !cmd_home ? 3'h0 : (hc_r == 3'h7 ? hc_r : hc_r + 3'h1);
      sc_r <= sc_r + 2'h1;
      if (cmd_go) begin
        tgt_r <= cmd_target;
      end else if (mc_moving && (!cmd_creep || sc_r == 2'h0)) begin
        mc_pos <= (mc_pos < tgt_r) ? mc_pos + 16'h1 : mc_pos - 16'h1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb.sv
/*
  Self-checking bench of the actuator push block with a motion model.
  Assumes the design files and acpush_mc_model are compiled first.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acpush_pkg::*;

  typedef struct {int id; logic [15:0] val;} acpush_note_t;
  logic core_clk, rst_b, pin_start, pin_hold_n, pin_estop_n;
  logic abs_variant, home_taught, tbl_wr, mc_alarm, mc_home_ok, mc_moving;
  logic tbl_reject, tbl_push_low, cmd_go, cmd_home, cmd_hold, cmd_creep;
  logic cmd_push_mode, out_home_done, out_alarm_n, out_estop_n;
  logic out_moving, out_pos_done, cmd_max_acc, clk_en;
  acpush_acc_t cmd_acc;
  acpush_idx_t pin_sel, tbl_idx, out_done_pos;
  acpush_fld_t tbl_fld;
  acpush_pos_t lead_res, tbl_data, mc_pos, cmd_target, cmd_speed, spd;
  acpush_pct_t mc_cur_pct, cmd_creep_rpm, cmd_push_pct;
  acpush_note_t q[$];
  acpush_note_t nt;
  event got;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 73223;
  string nm [0:18] = '{"home_done", "alarm_n", "estop_n", "moving",
    "pos_done", "done_pos", "reject", "push_low", "target", "speed",
    "creep", "creep_rpm", "cmd_home", "push_mode", "cmd_go", "cmd_hold",
    "acc", "max_acc", "push_pct"};

  acpush_top #(.PUSH_CYC(8)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .pin_start(pin_start), .pin_sel(pin_sel),
    .pin_hold_n(pin_hold_n), .pin_estop_n(pin_estop_n),
    .abs_variant(abs_variant), .home_taught(home_taught),
    .lead_res(lead_res), .tbl_wr(tbl_wr), .tbl_idx(tbl_idx),
    .tbl_fld(tbl_fld), .tbl_data(tbl_data), .tbl_reject(tbl_reject),
    .tbl_push_low(tbl_push_low), .mc_home_ok(mc_home_ok),
    .mc_alarm(mc_alarm), .mc_moving(mc_moving), .mc_pos(mc_pos),
    .mc_cur_pct(mc_cur_pct), .cmd_go(cmd_go), .cmd_home(cmd_home),
    .cmd_hold(cmd_hold), .cmd_target(cmd_target), .cmd_speed(cmd_speed),
    .cmd_acc(cmd_acc), .cmd_max_acc(cmd_max_acc),
    .cmd_push_pct(cmd_push_pct),
    .cmd_push_mode(cmd_push_mode), .cmd_creep(cmd_creep),
    .cmd_creep_rpm(cmd_creep_rpm), .out_home_done(out_home_done),
    .out_alarm_n(out_alarm_n), .out_estop_n(out_estop_n),
    .out_moving(out_moving), .out_pos_done(out_pos_done),
    .out_done_pos(out_done_pos));

  acpush_mc_model u_mc (.core_clk(core_clk), .rst_b(rst_b),
    .cmd_go(cmd_go), .cmd_home(cmd_home), .cmd_creep(cmd_creep),
    .cmd_target(cmd_target), .mc_home_ok(mc_home_ok),
    .mc_moving(mc_moving), .mc_pos(mc_pos));

  // ============================================================
  // Clock, watchdog, verdict
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end

  // ============================================================
  // Observation and comparison
  function automatic logic [15:0] see(input int id);
    case (id)
      0: return {15'h0, out_home_done};
      1: return {15'h0, out_alarm_n};
      2: return {15'h0, out_estop_n};
      3: return {15'h0, out_moving};
      4: return {15'h0, out_pos_done};
      5: return {12'h0, out_done_pos};
      6: return {15'h0, tbl_reject};
      7: return {15'h0, tbl_push_low};
      8: return cmd_target;
      9: return cmd_speed;
      10: return {15'h0, cmd_creep};
      11: return {8'h0, cmd_creep_rpm};
      12: return {15'h0, cmd_home};
      13: return {15'h0, cmd_push_mode};
      14: return {15'h0, cmd_go};
      16: return {8'h0, cmd_acc};
      17: return {15'h0, cmd_max_acc};
      18: return {8'h0, cmd_push_pct};
      default: return {15'h0, cmd_hold};
    endcase
  endfunction

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(got) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      check(nm[nt.id], see(nt.id), nt.val);
    end
  end

  task automatic note(input int id, input logic [15:0] v);
    q.push_back('{id, v});
    -> got;
  endtask

  task automatic wait_for(input int id, input logic [15:0] v, input int lim);
    for (int k = 0; k <= lim; k++) begin
      @(negedge core_clk);
      if (see(id) === v) break;
    end
    note(id, v);
  endtask

  // ============================================================
  // Drivers
  task automatic wr(input logic [3:0] i, input logic [2:0] f,
                    input logic [15:0] d, input logic rj, input logic pl);
    @(posedge core_clk);
    tbl_wr   <= 1'b1;
    tbl_idx  <= i;
    tbl_fld  <= f;
    tbl_data <= d;
    @(posedge core_clk);
    tbl_wr <= 1'b0;
    @(negedge core_clk);
    note(6, {15'h0, rj});
    note(7, {15'h0, pl});
  endtask

  task automatic go(input logic [3:0] i);
    @(posedge core_clk);
    pin_sel <= i;
    @(posedge core_clk);
    pin_start <= 1'b1;
    wait_for(4, 16'h0, 10);
    @(posedge core_clk);
    pin_start <= 1'b0;
  endtask

  // ============================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    pin_start = 1'b0;
    pin_sel = 4'h0;
    pin_hold_n = 1'b1;
    pin_estop_n = 1'b1;
    abs_variant = 1'b0;
    home_taught = 1'b0;
    lead_res = 16'h0004;
    tbl_wr = 1'b0;
    tbl_idx = 4'h0;
    tbl_fld = 3'h0;
    tbl_data = 16'h0000;
    mc_alarm = 1'b0;
    mc_cur_pct = 8'h00;
    clk_en = 1'b1;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_for(1, 16'h1, 2);
    wait_for(2, 16'h1, 0);
    note(0, 16'h0);
    wr(4'h3, 3'h1, 16'h1234, 1'b1, 1'b0);
    wr(4'h3, 3'h7, 16'h0000, 1'b1, 1'b0);
    for (int i = 0; i < 16; i++) wr(i[3:0], 3'h0, 16'(i * 16), 1'b0, 1'b0);
    wr(4'h0, 3'h7, 16'h0000, 1'b1, 1'b0);
    wr(4'h3, 3'h0, 16'h000b, 1'b0, 1'b0);
    spd = 16'($random(seed));
    wr(4'h3, 3'h1, spd, 1'b0, 1'b0);
    wr(4'h3, 3'h4, 16'h0002, 1'b0, 1'b0);
    wr(4'h3, 3'h2, 16'h0a5c, 1'b0, 1'b0);
    wr(4'h3, 3'h5, 16'h0003, 1'b0, 1'b0);
    wr(4'h1, 3'h6, 16'h0001, 1'b0, 1'b0);
    wr(4'h5, 3'h3, 16'h0032, 1'b0, 1'b0);
    wr(4'h5, 3'h4, 16'h0008, 1'b0, 1'b0);
    wr(4'h6, 3'h3, 16'h0010, 1'b0, 1'b1);
    wr(4'h6, 3'h3, 16'h0028, 1'b0, 1'b0);
    wr(4'h6, 3'h4, 16'h0008, 1'b0, 1'b0);
    go(4'h3);
    wait_for(12, 16'h1, 20);
    wait_for(0, 16'h1, 20);
    wait_for(14, 16'h1, 10);
    note(8, 16'h000c);
    note(9, spd);
    note(16, 16'h005c);
    note(17, 16'h0001);
    note(13, 16'h0);
    wait_for(3, 16'h1, 3);
    wait_for(4, 16'h1, 40);
    note(5, 16'h3);
    go(4'h5);
    wait_for(14, 16'h1, 20);
    note(13, 16'h1);
    note(18, 16'h0032);
    wait_for(10, 16'h1, 120);
    note(11, 16'h004b);
    @(posedge core_clk);
    mc_cur_pct <= 8'h40;
    repeat (4) @(posedge core_clk);
    mc_cur_pct <= 8'h00;
    @(posedge core_clk);
    mc_cur_pct <= 8'h40;
    repeat (5) @(posedge core_clk);
    wait_for(4, 16'h0, 0);
    wait_for(4, 16'h1, 8);
    note(5, 16'h5);
    note(10, 16'h1);
    @(posedge core_clk);
    mc_cur_pct <= 8'h00;
    go(4'h6);
    wait_for(5, 16'h6, 200);
    note(4, 16'h0);
    go(4'h1);
    wait_for(14, 16'h1, 20);
    note(8, 16'h0070);
    wait_for(4, 16'h1, 40);
    @(posedge core_clk);
    pin_hold_n <= 1'b0;
    wait_for(15, 16'h1, 5);
    @(posedge core_clk);
    pin_hold_n <= 1'b1;
    pin_estop_n <= 1'b0;
    wait_for(2, 16'h0, 6);
    note(0, 16'h1);
    @(posedge core_clk);
    pin_estop_n <= 1'b1;
    wait_for(12, 16'h1, 8);
    wait_for(2, 16'h1, 0);
    wait_for(0, 16'h1, 20);
    @(posedge core_clk);
    mc_alarm <= 1'b1;
    wait_for(1, 16'h0, 3);
    wait_for(0, 16'h0, 2);
    @(posedge core_clk);
    mc_alarm <= 1'b0;
    wait_for(1, 16'h1, 3);
    @(posedge core_clk);
    clk_en <= 1'b0;
    mc_alarm <= 1'b1;
    repeat (3) @(posedge core_clk);
    wait_for(1, 16'h1, 0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    mc_alarm <= 1'b0;
    @(posedge core_clk);
    rst_b <= 1'b0;
    abs_variant <= 1'b1;
    home_taught <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_for(0, 16'h1, 3);
    repeat (2) @(posedge core_clk);
    results();
  end
endmodule

`default_nettype wire
